// ### hdl/cfgl_top.sv
`timescale 1ns/1ns
// Function
// - Capture two bytes at power-up, then freeze
// - CPU reads both bytes at external addresses
// - Bit 7 picks watchdog clock: RC or CPU
// - Bit 6 disables reset pin function
// - Bit 5 sets port reset level
// - Bit 4 picks brownout threshold
// - Bit 2 enables input clock filter
// - Bits 1:0 pick CPU oscillator type
// - Program lock zero refuses program and config
// - Data lock zero refuses data, config and program
// - Both unlocked: erase, program, read allowed
// - Program locked only: data open, bank erase refused
// - Both locked: refuse all reads
module cfgl_top (
    clk,
    rst,
    ce,
    nv_rd_en,
    nv_rd_idx,
    nv_rd_data,
    cpu_rd,
    cpu_addr,
    cpu_rdata_r,
    cpu_hit_r,
    cfg_r,
    cfg_valid_r,
    core_rst_r,
    pgm_req_valid,
    pgm_req,
    pgm_grant_r,
    pgm_refuse_r,
    perm_r
);
    import cfgl_pkg::*;

    input wire logic clk; // System clock.
    input wire logic rst; // Power-up reset.
    input wire logic ce; // Clock enable.
    output logic nv_rd_en; // Store read strobe.
    output logic [0:0] nv_rd_idx; // Store byte index.
    input wire logic [7:0] nv_rd_data; // Store read data.
    input wire logic cpu_rd; // External-data read strobe.
    input wire logic [15:0] cpu_addr; // External-data address.
    output logic [7:0] cpu_rdata_r; // Read data.
    output logic cpu_hit_r; // Address matched a byte.
    output cfgl_opts_t cfg_r; // Decoded options.
    output logic cfg_valid_r; // Options valid.
    output logic core_rst_r; // Held until capture completes.
    input wire logic pgm_req_valid; // Programmer request strobe.
    input wire cfgl_req_t pgm_req; // Programmer request.
    output logic pgm_grant_r; // Request accepted.
    output logic pgm_refuse_r; // Request refused.
    output cfgl_perm_t perm_r; // Current permissions.

    // ==================================================================
    // Internal wires
    // ==================================================================
    logic [7:0] option_byte; // Captured option shadow.
    logic [7:0] lock_byte; // Captured lock shadow.
    logic load_done; // Capture finished.
    logic nv_en_w; // Loader read strobe.
    logic [0:0] nv_idx_w; // Loader read index.
    cfgl_perm_t perm_w; // Permissions from the lock byte.
    logic allow_w; // Current request is allowed.

    // ==================================================================
    // Capture
    // ==================================================================
    // The loader reads the store straight after reset; its strobes are
    // combinational, so they are retimed here to keep outputs registered.
    cfgl_loader u_loader (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .nv_rd_en(nv_en_w),
        .nv_rd_idx(nv_idx_w),
        .nv_rd_data(nv_rd_data),
        .option_r(option_byte),
        .lock_r(lock_byte),
        .done_r(load_done)
    );

    // Read strobe mirrors, registered for the output rule.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nv_rd_en <= 1'b0;
            nv_rd_idx <= CFGL_IDX_OPTION;
        end else if (ce) begin
            nv_rd_en <= nv_en_w;
            nv_rd_idx <= nv_idx_w;
        end
    end

    // Permission decode.
    cfgl_lock_policy u_policy (
        .lock_byte(lock_byte),
        .perm(perm_w)
    );

    // ==================================================================
    // Core reset and option outputs
    // ==================================================================
    // The core is held in reset until both shadows are loaded, so no
    // instruction can run on erased defaults.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_rst_r <= 1'b1;
            cfg_valid_r <= 1'b0;
            cfg_r <= '0;
        end else if (ce) begin
            core_rst_r <= !load_done;
            cfg_valid_r <= load_done;
            // Options come only from the frozen shadows; no CPU write path.
            cfg_r.watchdog_clock_select <= option_byte[CFGL_BIT_WDT_CLK];
            cfg_r.reset_pin_disable <= option_byte[CFGL_BIT_RST_DIS];
            cfg_r.port_reset_level <= option_byte[CFGL_BIT_PORT_LVL];
            cfg_r.brownout_threshold_select <= option_byte[CFGL_BIT_BOD_SEL];
            cfg_r.clock_filter_enable <= option_byte[CFGL_BIT_FILT_EN];
            cfg_r.osc_type <= cfgl_osc_t'({option_byte[CFGL_BIT_OSC_HI],
                                           option_byte[CFGL_BIT_OSC_LO]});
        end
    end

    // ==================================================================
    // CPU read-back
    // ==================================================================
    // Read-only: writes to these addresses are simply not decoded.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_rdata_r <= '0;
            cpu_hit_r <= 1'b0;
        end else if (ce) begin
            if (cpu_rd && cpu_addr == CFGL_XADDR_OPTION) begin
                cpu_rdata_r <= option_byte;
                cpu_hit_r <= 1'b1;
            end else if (cpu_rd && cpu_addr == CFGL_XADDR_LOCK) begin
                cpu_rdata_r <= lock_byte;
                cpu_hit_r <= 1'b1;
            end else begin
                cpu_rdata_r <= '0;
                cpu_hit_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Programmer access gate
    // ==================================================================
    // Pick the permission that matches the command and target area.
    always_comb begin
        allow_w = 1'b0;
        case (pgm_req.cmd)
            CFGL_CMD_READ: begin
                case (pgm_req.area)
                    CFGL_AREA_PROG: allow_w = perm_w.prog_read;
                    CFGL_AREA_DATA: allow_w = perm_w.data_read;
                    CFGL_AREA_CFG: allow_w = perm_w.cfg_access;
                    default: allow_w = 1'b0;
                endcase
            end
            CFGL_CMD_PROG, CFGL_CMD_PAGE_ERASE: begin
                case (pgm_req.area)
                    CFGL_AREA_PROG: allow_w = perm_w.prog_write;
                    CFGL_AREA_DATA: allow_w = perm_w.data_write;
                    CFGL_AREA_CFG: allow_w = perm_w.cfg_access;
                    default: allow_w = 1'b0;
                endcase
            end
            CFGL_CMD_BANK_ERASE: begin
                allow_w = perm_w.bank_erase;
            end
            default: begin
                allow_w = 1'b0;
            end
        endcase
        // Nothing is granted before the lock byte is known.
        allow_w = allow_w && load_done;
    end

    // Answer each request one cycle later with a grant or refuse pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pgm_grant_r <= 1'b0;
            pgm_refuse_r <= 1'b0;
            perm_r <= '0;
        end else if (ce) begin
            pgm_grant_r <= pgm_req_valid && allow_w;
            pgm_refuse_r <= pgm_req_valid && !allow_w;
            perm_r <= load_done ? perm_w : '0;
        end
    end

endmodule : cfgl_top

// ### hdl/cfgl_pkg.sv
package cfgl_pkg;

    // ==================================================================
    // Configuration byte map
    // ==================================================================
    // Width of each configuration byte.
    localparam int CFGL_BYTE_W = 8;
    // Index of the power-up option byte in the non-volatile store.
    localparam logic [0:0] CFGL_IDX_OPTION = 1'h0;
    // Index of the security lock byte in the non-volatile store.
    localparam logic [0:0] CFGL_IDX_LOCK = 1'h1;
    // External-data addresses where the CPU reads the bytes back.
    localparam logic [15:0] CFGL_XADDR_OPTION = 16'hFF00;
    localparam logic [15:0] CFGL_XADDR_LOCK = 16'hFF01;

    // Field positions in the power-up option byte.
    localparam int CFGL_BIT_WDT_CLK = 7;
    localparam int CFGL_BIT_RST_DIS = 6;
    localparam int CFGL_BIT_PORT_LVL = 5;
    localparam int CFGL_BIT_BOD_SEL = 4;
    localparam int CFGL_BIT_FILT_EN = 2;
    localparam int CFGL_BIT_OSC_HI = 1;
    localparam int CFGL_BIT_OSC_LO = 0;

    // Field positions in the security lock byte.
    localparam int CFGL_BIT_PROG_LOCK = 7;
    localparam int CFGL_BIT_DATA_LOCK = 6;

    // Value held in the shadows before capture completes (erased flash).
    localparam logic [7:0] CFGL_ERASED = 8'hFF;

    // ==================================================================
    // Enumerations
    // ==================================================================
    // Oscillator source codes.
    typedef enum logic [1:0] {
        CFGL_OSC_XTAL_HI = 2'b00,
        CFGL_OSC_RC455 = 2'b01,
        CFGL_OSC_XTAL_LO = 2'b10,
        CFGL_OSC_EXT = 2'b11
    } cfgl_osc_t;

    // Programmer command codes.
    typedef enum logic [2:0] {
        CFGL_CMD_READ = 3'b000,
        CFGL_CMD_PROG = 3'b001,
        CFGL_CMD_PAGE_ERASE = 3'b010,
        CFGL_CMD_BANK_ERASE = 3'b011,
        CFGL_CMD_IDLE = 3'b111
    } cfgl_cmd_t;

    // Programmer target areas.
    typedef enum logic [1:0] {
        CFGL_AREA_PROG = 2'b00,
        CFGL_AREA_DATA = 2'b01,
        CFGL_AREA_CFG = 2'b10,
        CFGL_AREA_NONE = 2'b11
    } cfgl_area_t;

    // Loader states.
    typedef enum logic [1:0] {
        CFGL_ST_RD_OPT = 2'b00,
        CFGL_ST_RD_LCK = 2'b01,
        CFGL_ST_DONE = 2'b10
    } cfgl_state_t;

    // ==================================================================
    // Carriers
    // ==================================================================
    // Decoded option settings handed to the rest of the chip.
    typedef struct packed {
        logic watchdog_clock_select;
        logic reset_pin_disable;
        logic port_reset_level;
        logic brownout_threshold_select;
        logic clock_filter_enable;
        cfgl_osc_t osc_type;
    } cfgl_opts_t;

    // Programmer request.
    typedef struct packed {
        cfgl_cmd_t cmd;
        cfgl_area_t area;
    } cfgl_req_t;

    // Access permissions per kind of operation.
    typedef struct packed {
        logic prog_read;
        logic prog_write;
        logic data_read;
        logic data_write;
        logic cfg_access;
        logic bank_erase;
    } cfgl_perm_t;

endpackage : cfgl_pkg

// ### hdl/cfgl_loader.sv
`timescale 1ns/1ns
// ======================================================================
// Power-up capture of the two configuration bytes
// ======================================================================
module cfgl_loader (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    output logic nv_rd_en,
    output logic [0:0] nv_rd_idx,
    input wire logic [7:0] nv_rd_data,
    output logic [7:0] option_r,
    output logic [7:0] lock_r,
    output logic done_r
);
    import cfgl_pkg::*;

    // Current capture state.
    cfgl_state_t state_r;

    // ==================================================================
    // Read sequence: one byte per cycle, then hold forever.
    // ==================================================================
    // The store returns data in the same cycle the index is presented.
    always_comb begin
        nv_rd_en = (state_r != CFGL_ST_DONE);
        nv_rd_idx = (state_r == CFGL_ST_RD_LCK) ? CFGL_IDX_LOCK : CFGL_IDX_OPTION;
    end

    // State and shadow capture; nothing is written after done.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= CFGL_ST_RD_OPT;
            option_r <= CFGL_ERASED;
            lock_r <= CFGL_ERASED;
            done_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                CFGL_ST_RD_OPT: begin
                    option_r <= nv_rd_data;
                    state_r <= CFGL_ST_RD_LCK;
                end
                CFGL_ST_RD_LCK: begin
                    lock_r <= nv_rd_data;
                    state_r <= CFGL_ST_DONE;
                    done_r <= 1'b1;
                end
                default: begin
                    // Held until the next power-up reset.
                    state_r <= CFGL_ST_DONE;
                end
            endcase
        end
    end

endmodule : cfgl_loader

// ### hdl/cfgl_lock_policy.sv
`timescale 1ns/1ns
// ======================================================================
// Lock bits to access permissions
// ======================================================================
module cfgl_lock_policy (
    input wire logic [7:0] lock_byte,
    output cfgl_pkg::cfgl_perm_t perm
);
    import cfgl_pkg::*;

    // Lock bits; zero means locked.
    logic prog_open;
    logic data_open;

    // Permission table; the unsupported 1/0 code counts as fully locked.
    always_comb begin
        prog_open = lock_byte[CFGL_BIT_PROG_LOCK];
        data_open = lock_byte[CFGL_BIT_DATA_LOCK];
        perm = '0;
        if (prog_open && data_open) begin
            perm = '1;
        end else if (!prog_open && data_open) begin
            perm.data_read = 1'b1;
            perm.data_write = 1'b1;
        end else begin
            perm = '0;
        end
        // Any lock bit at zero closes the configuration bytes.
        perm.cfg_access = prog_open && data_open;
    end

endmodule : cfgl_lock_policy

// ### verification/cfgl_nv_model.sv
`timescale 1ns/1ns
// ====================================================================
// Non-volatile store model holding the two configuration bytes
// ====================================================================
module cfgl_nv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] opt_byte,
    input wire logic [7:0] lock_byte,
    output logic [7:0] nv_rd_data
);
    logic [1:0] step_r; // Capture slots served since reset.

    // Counts the two capture slots; it stops afterwards so the store keeps returning the inverted lock byte.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_r <= 2'h0;
        end else if (ce && step_r != 2'h2) begin
            step_r <= step_r + 2'h1;
        end
    end

    // Option byte first, lock byte second; afterwards the inverse of the last
    // byte, so a late sample by the loader cannot pass by luck.
    always_comb begin
        case (step_r)
            2'h0: nv_rd_data = opt_byte;
            2'h1: nv_rd_data = lock_byte;
            default: nv_rd_data = ~lock_byte;
        endcase
    end
endmodule : cfgl_nv_model

// ### verification/cfgl_top_assertions.sv
`timescale 1ns/1ns
// ====================================================================
// Port checker for the configuration and lock block
// ====================================================================
module cfgl_top_chk
    import cfgl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_rdata_r,
    input wire logic cpu_hit_r,
    input wire cfgl_opts_t cfg_r,
    input wire logic cfg_valid_r,
    input wire logic core_rst_r,
    input wire logic pgm_req_valid,
    input wire cfgl_req_t pgm_req,
    input wire logic pgm_grant_r,
    input wire logic pgm_refuse_r,
    input wire cfgl_perm_t perm_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic opt_rd; // Read of the option byte taken.
    logic lock_rd; // Read of the lock byte taken.
    logic req; // Programmer request taken.
    assign opt_rd = ce && cpu_rd && cpu_addr == CFGL_XADDR_OPTION;
    assign lock_rd = ce && cpu_rd && cpu_addr == CFGL_XADDR_LOCK;
    assign req = ce && pgm_req_valid;

    // ====================================================================
    // Assertions
    // ====================================================================
    opt_fields_a: assert property (opt_rd && cfg_valid_r |=> cpu_hit_r &&
        cpu_rdata_r[7:4] == cfg_r[6:3] && cpu_rdata_r[2:0] == cfg_r[2:0])
        else $error("option readback disagrees with decoded options");
    lock_perm_a: assert property (lock_rd && cfg_valid_r |=> cpu_hit_r &&
        perm_r.prog_read == (cpu_rdata_r[7] & cpu_rdata_r[6]) &&
        perm_r.data_read == cpu_rdata_r[6]) else $error("lock byte and permissions disagree");
    addr_miss_a: assert property (ce && cpu_rd && !opt_rd && !lock_rd |=>
        !cpu_hit_r && cpu_rdata_r == 8'h00) else $error("unmapped read answered");
    read_quiet_a: assert property (ce && !cpu_rd |=> !cpu_hit_r && cpu_rdata_r == 8'h00)
        else $error("read data outside a read");
    one_answer_a: assert property (req |=> pgm_grant_r != pgm_refuse_r)
        else $error("request without exactly one answer");
    no_request_a: assert property (ce && !pgm_req_valid |=>
        !pgm_grant_r && !pgm_refuse_r) else $error("answer without a request");
    bank_erase_a: assert property (req && pgm_req.cmd == CFGL_CMD_BANK_ERASE &&
        !perm_r.bank_erase |=> pgm_refuse_r) else $error("bank erase not refused");
    cfg_lock_a: assert property (req && pgm_req.area == CFGL_AREA_CFG &&
        !perm_r.cfg_access |=> pgm_refuse_r) else $error("config access not refused");
    frozen_cfg_a: assert property (cfg_valid_r && $past(cfg_valid_r) |->
        $stable(cfg_r) && $stable(perm_r)) else $error("options changed after capture");
    core_hold_a: assert property (core_rst_r != cfg_valid_r)
        else $error("core reset and valid disagree");
    capture_time_a: assert property (ce && !cfg_valid_r |-> ##[1:3] cfg_valid_r)
        else $error("capture too slow");

    cover property (req && pgm_req.cmd == CFGL_CMD_BANK_ERASE ##1 pgm_grant_r);
    cover property (lock_rd ##1 cpu_hit_r);
    cover property (req && pgm_req.area == CFGL_AREA_DATA ##1 pgm_refuse_r);
endmodule : cfgl_top_chk

bind cfgl_top cfgl_top_chk u_chk (.clk, .rst, .ce, .cpu_rd, .cpu_addr, .cpu_rdata_r,
    .cpu_hit_r, .cfg_r, .cfg_valid_r, .core_rst_r, .pgm_req_valid, .pgm_req,
    .pgm_grant_r, .pgm_refuse_r, .perm_r);

// ### verification/tb_config_fuse_and_lock_logic.sv
`timescale 1ns/1ns
module tb_config_fuse_and_lock_logic;
    import cfgl_pkg::*;
    logic clk, rst, ce, cpu_rd, pgm_req_valid, cpu_hit_r;
    logic cfg_valid_r, core_rst_r, pgm_grant_r, pgm_refuse_r;
    logic nv_rd_en; // Store read strobe seen at the pin.
    logic [0:0] nv_rd_idx; // Store byte index seen at the pin.
    logic exp_ok; // Expected grant of the current programmer request.
    logic [8:0] exp_cfg; // Expected decoded options of the current test.
    logic [15:0] cpu_addr; // CPU read address.
    logic [7:0] nv_rd_data, cpu_rdata_r, opt_byte, lock_byte;
    cfgl_req_t pgm_req; // Programmer request.
    cfgl_opts_t cfg_r; // Decoded options.
    cfgl_perm_t perm_r; // Permissions.
    int miscompares, compares, cycles;
    // Option bytes cover every oscillator code; lock bytes every lock pair.
    logic [7:0] opts [4] = '{8'h08, 8'hF9, 8'h5E, 8'hAF};
    logic [7:0] locks [4] = '{8'hFF, 8'h7F, 8'hBF, 8'h3F};

    cfgl_top uut (.clk, .rst, .ce, .nv_rd_en, .nv_rd_idx, .nv_rd_data, .cpu_rd,
        .cpu_addr, .cpu_rdata_r, .cpu_hit_r, .cfg_r, .cfg_valid_r, .core_rst_r,
        .pgm_req_valid, .pgm_req, .pgm_grant_r, .pgm_refuse_r, .perm_r);
    cfgl_nv_model u_nv (.clk, .rst, .ce, .opt_byte, .lock_byte, .nv_rd_data);

    // ====================================================================
    // Clock, checks and closing
    // ====================================================================
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Compares one value; four-state equality so unknowns never match.
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // A hang counts as a mismatch; the full run needs well under 1000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    // Expected programmer answer: open, program-locked only, else fully locked.
    function automatic logic allow(input logic [1:0] lk, input int c, input int ar);
        if (lk == 2'h3) begin
            // Bank erase names no area, so it is granted whatever area is sent.
            return ar != 3 || c == 3;
        end
        if (lk == 2'h1) begin
            return ar == 1 && c != 3;
        end
        return 1'h0;
    endfunction : allow

    // ====================================================================
    // Access tasks
    // ====================================================================
    // Power-up with chosen store bytes; options must be valid at the third edge.
    task automatic power_up(input logic [7:0] o, input logic [7:0] l);
        int n;
        n = 0;
        opt_byte = o;
        lock_byte = l;
        rst = 1'h1;
        repeat (16) @(posedge clk);
        #1 rst = 1'h0;
        while (cfg_valid_r !== 1'h1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
            if (n == 2) begin
                check(9'({nv_rd_en, nv_rd_idx}), 9'h003);
            end
        end
        check(9'(n), 9'h003);
        check(9'(core_rst_r), 9'h000);
        check(9'({nv_rd_en, nv_rd_idx}), 9'h000);
    endtask : power_up

    task automatic cpu_read(input logic [15:0] a, input logic hit, input logic [7:0] exp);
        @(posedge clk);
        #1 cpu_rd = 1'h1;
        cpu_addr = a;
        @(posedge clk);
        #1 cpu_rd = 1'h0;
        check({cpu_hit_r, cpu_rdata_r}, {hit, exp});
    endtask : cpu_read

    task automatic pgm(input cfgl_cmd_t c, input cfgl_area_t ar, input logic ok);
        @(posedge clk);
        #1 pgm_req_valid = 1'h1;
        pgm_req = '{c, ar};
        @(posedge clk);
        #1 pgm_req_valid = 1'h0;
        check(9'({pgm_grant_r, pgm_refuse_r}), 9'({ok, ~ok}));
    endtask : pgm

    // ====================================================================
    // Main sequence
    // ====================================================================
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        cpu_rd = 1'h0;
        cpu_addr = 16'h0000;
        pgm_req_valid = 1'h0;
        pgm_req = '{CFGL_CMD_IDLE, CFGL_AREA_NONE};
        opt_byte = 8'h00;
        lock_byte = 8'h00;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        for (int i = 0; i < 4; i++) begin
            power_up(opts[i], locks[i]);
            exp_cfg = 9'({opts[i][7:4], opts[i][2:0]});
            check(9'(cfg_r), exp_cfg);
            cpu_read(CFGL_XADDR_OPTION, 1'h1, opts[i]);
            cpu_read(CFGL_XADDR_LOCK, 1'h1, locks[i]);
            cpu_read(16'hFF02, 1'h0, 8'h00);
            for (int c = 0; c < 4; c++) begin
                for (int ar = 0; ar < 4; ar++) begin
                    exp_ok = allow(locks[i][7:6], c, ar);
                    pgm(cfgl_cmd_t'(c), cfgl_area_t'(ar), exp_ok);
                end
            end
            // The idle code is no command at all and is always refused.
            pgm(CFGL_CMD_IDLE, CFGL_AREA_PROG, 1'h0);
            // With the clock enable low a read is not taken and nothing moves.
            @(posedge clk);
            #1 ce = 1'h0;
            cpu_rd = 1'h1;
            cpu_addr = CFGL_XADDR_OPTION;
            @(posedge clk);
            #1 cpu_rd = 1'h0;
            ce = 1'h1;
            check({cpu_hit_r, cpu_rdata_r}, 9'h000);
            check(9'(cfg_r), exp_cfg);
            $display("test %0d done", i);
        end
        stop_test();
    end
endmodule : tb_config_fuse_and_lock_logic
